// File: hw/atx_cfg.svh
// Purpose: named offsets, codes, field positions and reset values
// Assumes: included by its bare name wherever a number is needed
// Notes: byte offsets on a 32-bit register bus
`ifndef ATX_CFG_SVH
`define ATX_CFG_SVH

`define ATX_ADDR_W 6
`define ATX_OFF_INSTR 6'h00
`define ATX_OFF_ACC 6'h04
`define ATX_OFF_DPTR 6'h08
`define ATX_OFF_FILEX 6'h0C
`define ATX_OFF_RAMDATA 6'h10
`define ATX_OFF_CLKCTRL 6'h14
`define ATX_OFF_PU0 6'h18
`define ATX_OFF_PU1 6'h1C
`define ATX_OFF_STATUS 6'h20

`define ATX_STORE_PAT 6'h2B
`define ATX_CODE_CLK 10'h216
`define ATX_CODE_PU0 10'h22D
`define ATX_CODE_PU1 10'h22E

`define ATX_RESP_OKAY 2'h0
`define ATX_RESP_SLVERR 2'h2

`define ATX_ST_CARRY 0
`define ATX_ST_SKIP 1
`define ATX_ST_ILL 2
`define ATX_ST_BUSY 3

`define ATX_RST_NIB 4'h0
`define ATX_RST_CODE 10'h000
`define ATX_RST_WORD 32'h0000_0000

`endif

// File: hw/atx_pkg.sv
// Purpose: shared types of the accumulator transfer executor
// Assumes: used as atx_pkg::name, never imported
// Notes: one-hot codes written out
package atx_pkg;

  typedef enum logic [4:0] {
    ATX_OP_NONE  = 5'h01,
    ATX_OP_STORE = 5'h02,
    ATX_OP_CLK   = 5'h04,
    ATX_OP_PU0   = 5'h08,
    ATX_OP_PU1   = 5'h10
  } atx_op_t;

  typedef enum logic [1:0] {
    ATX_WR_IDLE = 2'h1,
    ATX_WR_RESP = 2'h2
  } atx_wr_t;

  typedef enum logic [1:0] {
    ATX_RD_IDLE = 2'h1,
    ATX_RD_DATA = 2'h2
  } atx_rd_t;

endpackage

// File: hw/atx_dec_if.sv
// Purpose: carries an instruction word to the decoder and its class back
// Assumes: purely combinational path
// Notes: imm is the low nibble of the word
`timescale 1ns/1ps
interface atx_dec_if;
  logic [9:0] code;
  atx_pkg::atx_op_t op;
  logic [3:0] imm;
  modport core (output code, input op, input imm);
  modport dec (input code, output op, output imm);
endinterface

// File: hw/atx_decode.sv
// Purpose: classifies a 10-bit instruction word
// Assumes: word is stable while read
// Notes: words outside this group come back as none
`timescale 1ns/1ps
`include "atx_cfg.svh"
module atx_decode (
  atx_dec_if.dec dif
);

  function automatic logic is_code(input logic [9:0] c,
                                   input logic [9:0] k);
    return c == k;
  endfunction

  always_comb begin
    dif.imm = dif.code[3:0];
    if (dif.code[9:4] == `ATX_STORE_PAT) begin
      dif.op = atx_pkg::ATX_OP_STORE;
    end else if (is_code(dif.code, `ATX_CODE_CLK)) begin
      dif.op = atx_pkg::ATX_OP_CLK;
    end else if (is_code(dif.code, `ATX_CODE_PU0)) begin
      dif.op = atx_pkg::ATX_OP_PU0;
    end else if (is_code(dif.code, `ATX_CODE_PU1)) begin
      dif.op = atx_pkg::ATX_OP_PU1;
    end else begin
      dif.op = atx_pkg::ATX_OP_NONE;
    end
  end

endmodule

// File: hw/atx_top.sv
// Purpose: executes the accumulator transfer group behind AXI4-Lite
// Assumes: one write and one read in flight at most
// Notes: writing the instruction register runs it one cycle later
`timescale 1ns/1ps
`include "atx_cfg.svh"

// Functional notes
// - a word whose upper six bits are 101011 stores the accumulator into RAM at the data pointer in one cycle.
// - that store also XORs the file register with the low four bits, any value 0 to 15.
// - the XOR result is written back into the file register for the next instruction.
// - the full ten-bit clock control code copies the accumulator into the clock control register.
// - code 1000101101 copies the accumulator into pull-up control register zero in one cycle.
// - a distinct code copies the accumulator into pull-up control register one.
module atx_top #(
  parameter int RAM_WORDS = 256,
  parameter int DP_W = 8
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic [`ATX_ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [`ATX_ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [3:0] CLOCK_CTRL,
  output logic [3:0] PULLUP_ZERO,
  output logic [3:0] PULLUP_ONE,
  output logic EXEC_DONE
);

  // refused at elaboration: the pointer must reach every ram word
  if (DP_W < 1 || DP_W > 16 || RAM_WORDS < 1 ||
      RAM_WORDS > (1 << DP_W)) begin : g_bad_size
    $error("atx_top: RAM_WORDS does not fit DP_W");
  end

  // byte-lane merge of a write into a register image
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [`ATX_ADDR_W-1:0] a);
    return a == `ATX_OFF_INSTR || a == `ATX_OFF_ACC ||
           a == `ATX_OFF_DPTR || a == `ATX_OFF_FILEX ||
           a == `ATX_OFF_RAMDATA || a == `ATX_OFF_CLKCTRL ||
           a == `ATX_OFF_PU0 || a == `ATX_OFF_PU1 ||
           a == `ATX_OFF_STATUS;
  endfunction

  atx_dec_if dif ();

  atx_decode u_dec (
    .dif(dif)
  );

  // core state
  logic [9:0] instr_r, instr_nxt;
  logic [3:0] acc_r, acc_nxt;
  logic [DP_W-1:0] dp_r, dp_nxt;
  logic [3:0] file_r, file_nxt;
  logic carry_r, carry_nxt;
  logic ill_r, ill_nxt;
  logic pend_r, pend_nxt;
  logic [3:0] clk_r, clk_nxt;
  logic [3:0] pu0_r, pu0_nxt;
  logic [3:0] pu1_r, pu1_nxt;
  logic done_r, done_nxt;

  // bus state
  atx_pkg::atx_wr_t wst_r, wst_nxt;
  atx_pkg::atx_rd_t rst_r, rst_nxt;
  logic aw_have_r, aw_have_nxt;
  logic w_have_r, w_have_nxt;
  logic [`ATX_ADDR_W-1:0] waddr_r, waddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic awready_r, awready_nxt;
  logic wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic arready_r, arready_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;

  // memory
  logic [3:0] ram [RAM_WORDS];
  logic ram_we;
  logic [3:0] ram_wd;
  logic dp_ok;
  logic [3:0] ram_rd;
  logic commit;
  logic [31:0] st_word;

  assign dif.code = instr_r;
  assign dp_ok = 32'(dp_r) < RAM_WORDS;
  assign ram_rd = dp_ok ? ram[dp_r] : `ATX_RST_NIB;
  assign commit = aw_have_r && w_have_r && wst_r == atx_pkg::ATX_WR_IDLE;

  always_comb begin
    st_word = `ATX_RST_WORD;
    st_word[`ATX_ST_CARRY] = carry_r;
    st_word[`ATX_ST_SKIP] = 1'b0;
    st_word[`ATX_ST_ILL] = ill_r;
    st_word[`ATX_ST_BUSY] = pend_r;
  end

  // register writes from the bus and instruction execution
  always_comb begin
    logic [31:0] m;
    m = `ATX_RST_WORD;
    instr_nxt = instr_r;
    acc_nxt = acc_r;
    dp_nxt = dp_r;
    file_nxt = file_r;
    carry_nxt = carry_r;
    ill_nxt = ill_r;
    pend_nxt = 1'b0;
    clk_nxt = clk_r;
    pu0_nxt = pu0_r;
    pu1_nxt = pu1_r;
    done_nxt = 1'b0;
    ram_we = 1'b0;
    ram_wd = acc_r;
    if (commit) begin
      case (waddr_r)
        `ATX_OFF_INSTR: begin
          m = merge(32'(instr_r), wdata_r, wstrb_r);
          instr_nxt = m[9:0];
          pend_nxt = |wstrb_r[1:0];
        end
        `ATX_OFF_ACC: begin
          m = merge(32'(acc_r), wdata_r, wstrb_r);
          acc_nxt = m[3:0];
        end
        `ATX_OFF_DPTR: begin
          m = merge(32'(dp_r), wdata_r, wstrb_r);
          dp_nxt = m[DP_W-1:0];
        end
        `ATX_OFF_FILEX: begin
          m = merge(32'(file_r), wdata_r, wstrb_r);
          file_nxt = m[3:0];
        end
        `ATX_OFF_RAMDATA: begin
          m = merge(32'(ram_rd), wdata_r, wstrb_r);
          ram_wd = m[3:0];
          ram_we = wstrb_r[0] && dp_ok;
        end
        `ATX_OFF_CLKCTRL: begin
          m = merge(32'(clk_r), wdata_r, wstrb_r);
          clk_nxt = m[3:0];
        end
        `ATX_OFF_PU0: begin
          m = merge(32'(pu0_r), wdata_r, wstrb_r);
          pu0_nxt = m[3:0];
        end
        `ATX_OFF_PU1: begin
          m = merge(32'(pu1_r), wdata_r, wstrb_r);
          pu1_nxt = m[3:0];
        end
        `ATX_OFF_STATUS: begin
          if (wstrb_r[0]) begin
            carry_nxt = wdata_r[`ATX_ST_CARRY];
            if (wdata_r[`ATX_ST_ILL]) begin
              ill_nxt = 1'b0;
            end
          end
        end
        default: begin
          m = `ATX_RST_WORD;
        end
      endcase
    end
    // execution comes a cycle after the write, so no register is
    // ever written by both paths at once; carry is left alone
    if (pend_r) begin
      done_nxt = 1'b1;
      case (dif.op)
        atx_pkg::ATX_OP_STORE: begin
          ram_we = dp_ok;
          ram_wd = acc_r;
          file_nxt = file_r ^ dif.imm;
        end
        atx_pkg::ATX_OP_CLK: begin
          clk_nxt = acc_r;
        end
        atx_pkg::ATX_OP_PU0: begin
          pu0_nxt = acc_r;
        end
        atx_pkg::ATX_OP_PU1: begin
          pu1_nxt = acc_r;
        end
        default: begin
          ill_nxt = 1'b1; // set wins over the clear above
        end
      endcase
    end
  end

  // memory has no reset; contents are undefined until written
  always_ff @(posedge MCLK) begin
    if (ram_we) begin
      ram[dp_r] <= ram_wd;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      instr_r <= `ATX_RST_CODE;
      acc_r <= `ATX_RST_NIB;
      dp_r <= '0;
      file_r <= `ATX_RST_NIB;
      carry_r <= 1'b0;
      ill_r <= 1'b0;
      pend_r <= 1'b0;
      clk_r <= `ATX_RST_NIB;
      pu0_r <= `ATX_RST_NIB;
      pu1_r <= `ATX_RST_NIB;
      done_r <= 1'b0;
    end else begin
      instr_r <= instr_nxt;
      acc_r <= acc_nxt;
      dp_r <= dp_nxt;
      file_r <= file_nxt;
      carry_r <= carry_nxt;
      ill_r <= ill_nxt;
      pend_r <= pend_nxt;
      clk_r <= clk_nxt;
      pu0_r <= pu0_nxt;
      pu1_r <= pu1_nxt;
      done_r <= done_nxt;
    end
  end

  // write channel: address and data taken in either order
  always_comb begin
    wst_nxt = wst_r;
    aw_have_nxt = aw_have_r;
    w_have_nxt = w_have_r;
    waddr_nxt = waddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    if (awready_r && S_AXI_AWVALID) begin
      aw_have_nxt = 1'b1;
      waddr_nxt = S_AXI_AWADDR;
    end
    if (wready_r && S_AXI_WVALID) begin
      w_have_nxt = 1'b1;
      wdata_nxt = S_AXI_WDATA;
      wstrb_nxt = S_AXI_WSTRB;
    end
    case (wst_r)
      atx_pkg::ATX_WR_IDLE: begin
        if (commit) begin
          wst_nxt = atx_pkg::ATX_WR_RESP;
          bvalid_nxt = 1'b1;
          bresp_nxt = mapped(waddr_r) ? `ATX_RESP_OKAY
                                      : `ATX_RESP_SLVERR;
          aw_have_nxt = 1'b0;
          w_have_nxt = 1'b0;
        end
      end
      atx_pkg::ATX_WR_RESP: begin
        if (S_AXI_BREADY) begin
          wst_nxt = atx_pkg::ATX_WR_IDLE;
          bvalid_nxt = 1'b0;
        end
      end
      default: begin
        wst_nxt = atx_pkg::ATX_WR_IDLE;
        bvalid_nxt = 1'b0;
      end
    endcase
    awready_nxt = !aw_have_nxt && wst_nxt == atx_pkg::ATX_WR_IDLE;
    wready_nxt = !w_have_nxt && wst_nxt == atx_pkg::ATX_WR_IDLE;
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      wst_r <= atx_pkg::ATX_WR_IDLE;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      waddr_r <= '0;
      wdata_r <= `ATX_RST_WORD;
      wstrb_r <= '0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `ATX_RESP_OKAY;
    end else begin
      wst_r <= wst_nxt;
      aw_have_r <= aw_have_nxt;
      w_have_r <= w_have_nxt;
      waddr_r <= waddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
    end
  end

  // read channel: data one cycle after the address is taken
  always_comb begin
    rst_nxt = rst_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    case (rst_r)
      atx_pkg::ATX_RD_IDLE: begin
        if (arready_r && S_AXI_ARVALID) begin
          rst_nxt = atx_pkg::ATX_RD_DATA;
          rvalid_nxt = 1'b1;
          rresp_nxt = `ATX_RESP_OKAY;
          case (S_AXI_ARADDR)
            `ATX_OFF_INSTR: rdata_nxt = 32'(instr_r);
            `ATX_OFF_ACC: rdata_nxt = 32'(acc_r);
            `ATX_OFF_DPTR: rdata_nxt = 32'(dp_r);
            `ATX_OFF_FILEX: rdata_nxt = 32'(file_r);
            `ATX_OFF_RAMDATA: rdata_nxt = 32'(ram_rd);
            `ATX_OFF_CLKCTRL: rdata_nxt = 32'(clk_r);
            `ATX_OFF_PU0: rdata_nxt = 32'(pu0_r);
            `ATX_OFF_PU1: rdata_nxt = 32'(pu1_r);
            `ATX_OFF_STATUS: rdata_nxt = st_word;
            default: begin
              rdata_nxt = `ATX_RST_WORD;
              rresp_nxt = `ATX_RESP_SLVERR;
            end
          endcase
        end
      end
      atx_pkg::ATX_RD_DATA: begin
        if (S_AXI_RREADY) begin
          rst_nxt = atx_pkg::ATX_RD_IDLE;
          rvalid_nxt = 1'b0;
        end
      end
      default: begin
        rst_nxt = atx_pkg::ATX_RD_IDLE;
        rvalid_nxt = 1'b0;
      end
    endcase
    arready_nxt = rst_nxt == atx_pkg::ATX_RD_IDLE;
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_r <= atx_pkg::ATX_RD_IDLE;
      rvalid_r <= 1'b0;
      rdata_r <= `ATX_RST_WORD;
      rresp_r <= `ATX_RESP_OKAY;
      arready_r <= 1'b0;
    end else begin
      rst_r <= rst_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      arready_r <= arready_nxt;
    end
  end

  assign S_AXI_AWREADY = awready_r;
  assign S_AXI_WREADY = wready_r;
  assign S_AXI_BVALID = bvalid_r;
  assign S_AXI_BRESP = bresp_r;
  assign S_AXI_ARREADY = arready_r;
  assign S_AXI_RVALID = rvalid_r;
  assign S_AXI_RDATA = rdata_r;
  assign S_AXI_RRESP = rresp_r;
  assign CLOCK_CTRL = clk_r;
  assign PULLUP_ZERO = pu0_r;
  assign PULLUP_ONE = pu1_r;
  assign EXEC_DONE = done_r;

endmodule

// File: verif/atx_top_sva.sv
// Purpose: port-level checks of the transfer executor
// Assumes: single clock domain, async active-low reset
// Notes: bound onto atx_top
`timescale 1ns/1ps
module atx_top_sva #(
  parameter int RAM_WORDS = 256,
  parameter int DP_W = 8
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [3:0] CLOCK_CTRL,
  input wire logic [3:0] PULLUP_ZERO,
  input wire logic [3:0] PULLUP_ONE,
  input wire logic EXEC_DONE
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);

  sequence s_wr_taken;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence s_wr_answer;
    ##2 S_AXI_BVALID;
  endsequence
  sequence s_wr_commit;
    $rose(S_AXI_BVALID) || $rose(EXEC_DONE);
  endsequence

  exec_pulse_a: assert property (
    EXEC_DONE |=> !EXEC_DONE) else $error("exec pulse too long");
  exec_cause_a: assert property (
    $rose(EXEC_DONE) |-> $past(S_AXI_BVALID))
    else $error("exec without a write");
  clk_ctrl_a: assert property (
    !$stable(CLOCK_CTRL) |-> s_wr_commit) else $error("clock ctrl moved");
  pullup_zero_a: assert property (
    !$stable(PULLUP_ZERO) |-> s_wr_commit) else $error("pull-up 0 moved");
  pullup_one_a: assert property (
    !$stable(PULLUP_ONE) |-> s_wr_commit) else $error("pull-up 1 moved");
  wr_answer_a: assert property (
    s_wr_taken |-> s_wr_answer) else $error("write answer late");
  rd_answer_a: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read answer late");
  b_hold_a: assert property (
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");
  r_hold_a: assert property (
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped");
  busy_refuse_a: assert property (
    S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("took write while busy");
endmodule

bind atx_top atx_top_sva #(.RAM_WORDS(RAM_WORDS), .DP_W(DP_W)) u_sva (
  .MCLK(MCLK), .RST_N(RST_N), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY), .CLOCK_CTRL(CLOCK_CTRL),
  .PULLUP_ZERO(PULLUP_ZERO), .PULLUP_ONE(PULLUP_ONE),
  .EXEC_DONE(EXEC_DONE));

// File: verif/test_acc_transfer_instr_exec.sv
// Purpose: random self-checking bench for the transfer executor
// Assumes: bus tasks start just after a rising edge
// Notes: model held in plain integers and an associative ram
`timescale 1ns/1ps
`include "atx_cfg.svh"
module test_acc_transfer_instr_exec;
  logic MCLK = 0;
  logic RST_N = 0;
  logic [5:0] awa = 0, ara = 0;
  logic [2:0] awp = 0, arp = 0;
  logic awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic [31:0] wd = 0;
  logic [3:0] ws = 4'hF;
  logic awr, wrd, bv, arr, rv, done;
  logic [1:0] bresp, rresp;
  logic [31:0] rdat;
  logic [3:0] clk_o, pu0_o, pu1_o;
  int failures = 0;
  int total_checks = 0;
  int execs = 0;

  atx_top u_dut (.MCLK(MCLK), .RST_N(RST_N), .S_AXI_AWADDR(awa),
    .S_AXI_AWPROT(awp), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wrd), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(bry), .S_AXI_ARADDR(ara), .S_AXI_ARPROT(arp),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry),
    .CLOCK_CTRL(clk_o), .PULLUP_ZERO(pu0_o), .PULLUP_ONE(pu1_o),
    .EXEC_DONE(done));

  always #2.5 MCLK = ~MCLK;
  // counts cycles with the pulse high, so a stretched pulse shows up
  always @(posedge MCLK) if (done === 1'b1) execs++;

  task automatic report_and_stop;
    if (failures == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask

  task automatic stall;
    failures++;
    $display("unexpected at %0t: bus wait ran out", $time);
    report_and_stop();
  endtask

  // ready raised only after valid is seen, so hold checks get exercised
  task automatic wr(input logic [5:0] a, input int d, input logic [1:0] e);
    int n;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    awp <= 3'($urandom);
    for (n = 0; n < 30; n++) begin
      @(posedge MCLK);
      if (awv && awr === 1'b1) awv <= 1'b0;
      if (wv && wrd === 1'b1) wv <= 1'b0;
      if (bry && bv === 1'b1) break;
      if (bv === 1'b1) bry <= 1'b1;
    end
    bry <= 1'b0;
    if (n == 30) stall();
    chk(32'(bresp), 32'(e));
  endtask

  task automatic rd(input logic [5:0] a, input int d, input logic [1:0] e);
    int n;
    ara <= a;
    arv <= 1'b1;
    arp <= 3'($urandom);
    for (n = 0; n < 30; n++) begin
      @(posedge MCLK);
      if (arv && arr === 1'b1) arv <= 1'b0;
      if (rry && rv === 1'b1) break;
      if (rv === 1'b1) rry <= 1'b1;
    end
    rry <= 1'b0;
    if (n == 30) stall();
    chk(rdat, d);
    chk(32'(rresp), 32'(e));
  endtask

  initial begin
    int acc, dp, fx, cy, il, clk, p0, p1, code, k, base;
    int ram [int];
    void'($urandom(28544));
    acc = 0;
    dp = 0;
    fx = 0;
    repeat (6) @(posedge MCLK);
    RST_N <= 1'b1;
    @(posedge MCLK);
    chk(32'({clk_o, pu0_o, pu1_o, done}), 32'h0000_0000);
    rd(`ATX_OFF_STATUS, 0, `ATX_RESP_OKAY);
    clk = $urandom % 16;
    p0 = $urandom % 16;
    p1 = $urandom % 16;
    wr(`ATX_OFF_CLKCTRL, clk, `ATX_RESP_OKAY);
    wr(`ATX_OFF_PU0, p0, `ATX_RESP_OKAY);
    wr(`ATX_OFF_PU1, p1, `ATX_RESP_OKAY);
    // no lanes enabled: the register must keep its value
    ws <= 4'h0;
    wr(`ATX_OFF_PU0, p0 ^ 15, `ATX_RESP_OKAY);
    ws <= 4'hF;
    wr(6'h24, 5, `ATX_RESP_SLVERR);
    rd(6'h24, 0, `ATX_RESP_SLVERR);
    rd(`ATX_OFF_PU0, p0, `ATX_RESP_OKAY);
    for (k = 0; k < 80; k++) begin
      acc = $urandom % 16;
      wr(`ATX_OFF_ACC, acc, `ATX_RESP_OKAY);
      if (k % 3 == 0) begin
        dp = $urandom % 256;
        wr(`ATX_OFF_DPTR, dp, `ATX_RESP_OKAY);
      end
      // file register reloaded rarely so xor results chain across stores
      if (k % 7 == 0) begin
        fx = $urandom % 16;
        wr(`ATX_OFF_FILEX, fx, `ATX_RESP_OKAY);
      end
      cy = $urandom % 2;
      il = 0;
      wr(`ATX_OFF_STATUS, 4 + cy, `ATX_RESP_OKAY);
      case (k % 5)
        0: code = 32'h0000_02B0 + k / 5;
        1: code = `ATX_CODE_CLK;
        2: code = `ATX_CODE_PU0;
        3: code = `ATX_CODE_PU1;
        default: code = 32'h0000_0300 + $urandom % 256;
      endcase
      base = execs;
      wr(`ATX_OFF_INSTR, code, `ATX_RESP_OKAY);
      repeat (2) @(posedge MCLK);
      case (k % 5)
        0: begin
          ram[dp] = acc;
          fx = fx ^ (k / 5);
        end
        1: clk = acc;
        2: p0 = acc;
        3: p1 = acc;
        default: il = 1;
      endcase
      if (il == 0) chk(execs - base, 1);
      chk(32'(clk_o), clk);
      chk(32'(pu0_o), p0);
      chk(32'(pu1_o), p1);
      rd(`ATX_OFF_FILEX, fx, `ATX_RESP_OKAY);
      if (k % 5 == 0) rd(`ATX_OFF_RAMDATA, ram[dp], `ATX_RESP_OKAY);
      rd(`ATX_OFF_STATUS, il * 4 + cy, `ATX_RESP_OKAY);
    end
    report_and_stop();
  end
endmodule
